// [include/srm_consts.vh]
// Constants for the service request mask logic.
`ifndef SRM_CONSTS_VH
`define SRM_CONSTS_VH

// Data widths.
`define SRM_W          8
`define SRM_MSB        7

// Status summary byte bit positions.
`define SRM_B_ALARM    0
`define SRM_B_TRIG     1
`define SRM_B_READY    2
`define SRM_B_SCAN     3
`define SRM_B_MSG      4
`define SRM_B_EVENT    5
`define SRM_B_SUMMARY  6
`define SRM_B_OVERRUN  7

// Enable bits that exist; the request summary bit has no enable.
`define SRM_ENABLE_BITS 8'hBF

// Reset and clear values.
`define SRM_MASK_RESET  8'h00
`define SRM_ZERO_BYTE   8'h00

// Synchroniser stage reset value.
`define SRM_SYNC_RESET  1'b0

// Open-drain request pin: its data bit and the released enable level.
`define SRM_SRQ_DATA     1'b0
`define SRM_SRQ_RELEASED 1'b1

`endif

// [rtl/srm_sync.v]
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/10ps
`include "srm_consts.vh"

module srm_sync #(
  parameter WIDTH = 8
) (
  // Clock, reset and enable.
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  // Levels from another domain.
  input  wire [WIDTH-1:0] async_in,
  // Levels safe for this domain.
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_ff;
      reg stable_ff;
      // Only the second stage reads the first.
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_ff   <= `SRM_SYNC_RESET;
          stable_ff <= `SRM_SYNC_RESET;
        end else if (ce) begin
          meta_ff   <= async_in[i];
          stable_ff <= meta_ff;
        end
      end
      assign sync_out[i] = stable_ff;
    end
  endgenerate

endmodule // srm_sync

// [rtl/srm_top.v]
// Service request mask and request generation toward the bus controller.
//
// Function
// - Mask bits mirror status byte bits; bit 6 is summary, no enable.
// - Set status condition with enabled mask bit asserts bus request.
// - Several conditions may be enabled; combined mask is their OR.
// - Mask held until next executed write, power-on command or device clear.
// - Bit 7 requests service on acquisition buffer overrun.
// - Bit 5 requests service when an enabled event has occurred.
// - Bit 4 requests service when response data waits in output queue.
// - Bit 3 requests service when a complete scan is available.
// - Bit 2 requests service when command set finished, device ready.
// - Bit 1 requests service on valid trigger start or stop event.
// - Bit 0 requests service on a valid alarm condition.
// - Mask is zero after power-on; writing zero disables all requests.
`timescale 1ns/10ps
`include "srm_consts.vh"

module srm_top (
  // Clock, reset and enable.
  input  wire               clk,
  input  wire               rst,
  input  wire               ce,
  // Mask write command from the command parser.
  input  wire               mask_wr,
  input  wire [`SRM_MSB:0]  mask_wr_data,
  // Execute command closing a command string.
  input  wire               exec_cmd,
  // Mask query command and its answer.
  input  wire               mask_rd,
  output wire [`SRM_MSB:0]  mask_rd_data,
  output wire               mask_rd_valid,
  // Clear sources.
  input  wire               por_cmd,
  input  wire               dev_clear,
  // Status conditions from the acquisition front end (other domain).
  input  wire               cond_overrun,
  input  wire               cond_event,
  input  wire               cond_msg,
  input  wire               cond_scan,
  input  wire               cond_ready,
  input  wire               cond_trig,
  input  wire               cond_alarm,
  // Status summary byte and programmed mask for serial poll.
  output wire [`SRM_MSB:0]  status_summary_byte,
  output wire [`SRM_MSB:0]  request_enable_mask,
  // Open-drain service request line.
  output wire               srq_out,
  output wire               srq_oe_n
);

  // Asynchronous conditions placed at their status byte positions. They
  // are levels: a condition that pulses for less than one clock may be
  // missed, so the front end must hold each one until it is serviced.
  wire [`SRM_MSB:0] cond_raw;
  wire [`SRM_MSB:0] cond_sync;

  assign cond_raw[`SRM_B_OVERRUN] = cond_overrun;
  assign cond_raw[`SRM_B_SUMMARY] = 1'b0;
  assign cond_raw[`SRM_B_EVENT]   = cond_event;
  assign cond_raw[`SRM_B_MSG]     = cond_msg;
  assign cond_raw[`SRM_B_SCAN]    = cond_scan;
  assign cond_raw[`SRM_B_READY]   = cond_ready;
  assign cond_raw[`SRM_B_TRIG]    = cond_trig;
  assign cond_raw[`SRM_B_ALARM]   = cond_alarm;

  srm_sync #(
    .WIDTH    (`SRM_W)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .async_in (cond_raw),
    .sync_out (cond_sync)
  );

  // Mask state: the live mask and the value collected within a string.
  reg  [`SRM_MSB:0] mask_ff;
  reg  [`SRM_MSB:0] nxt_mask;
  reg  [`SRM_MSB:0] pend_ff;
  reg  [`SRM_MSB:0] nxt_pend;
  reg               pend_vld_ff;
  reg               nxt_pend_vld;

  // Query answer.
  reg  [`SRM_MSB:0] rd_data_ff;
  reg               rd_valid_ff;

  // Status byte and request line; both pin flops drive outputs directly.
  reg  [`SRM_MSB:0] stb_ff;
  reg  [`SRM_MSB:0] nxt_stb;
  reg               nxt_srq;
  reg               srq_out_ff;
  reg               srq_oe_n_ff;

  wire              clear_all;
  wire [`SRM_MSB:0] wr_value;
  wire [`SRM_MSB:0] enabled_hits;

  // Power-on command and device clear both wipe the mask at once. A clear
  // in the same cycle as a write wins and drops the pending value, so a
  // stale write can never come back after a device clear.
  assign clear_all = por_cmd | dev_clear;

  // Bit 6 has no enable, so it can never be stored.
  assign wr_value = mask_wr_data & `SRM_ENABLE_BITS;

  // Mask update. Writes are deferred: they collect in the pending value
  // and take effect on execute. Nonzero writes in one string without execute OR
  // together, so sending the summed value once gives the same result; a zero write clears the pending value.
  always @* begin
    nxt_mask     = mask_ff;
    nxt_pend     = pend_ff;
    nxt_pend_vld = pend_vld_ff;
    if (clear_all) begin
      nxt_mask     = `SRM_MASK_RESET;
      nxt_pend     = `SRM_MASK_RESET;
      nxt_pend_vld = 1'b0;
    end else begin
      if (mask_wr) begin
        if (wr_value == `SRM_ZERO_BYTE) begin
          nxt_pend = `SRM_ZERO_BYTE;
        end else begin
          nxt_pend = pend_ff | wr_value;
        end
        nxt_pend_vld = 1'b1;
      end
      // A write in the same cycle as execute joins the committed value.
      if (exec_cmd && nxt_pend_vld) begin
        nxt_mask     = nxt_pend;
        nxt_pend     = `SRM_MASK_RESET;
        nxt_pend_vld = 1'b0;
      end
    end
  end

  // One lane per status bit. A lane counts toward the request only where
  // its enable bit is set; the summary lane has no enable, so it can never
  // feed back into its own value.
  genvar b;
  generate
    for (b = 0; b < `SRM_W; b = b + 1) begin : g_lane
      if (b == `SRM_B_SUMMARY) begin : g_summary
        assign enabled_hits[b] = 1'b0;
      end else begin : g_cond
        assign enabled_hits[b] = cond_sync[b] & mask_ff[b];
      end
    end
  endgenerate

  // Status byte: conditions at their positions, bit 6 the summary.
  always @* begin
    nxt_stb = cond_sync & `SRM_ENABLE_BITS;
    nxt_stb[`SRM_B_SUMMARY] = |enabled_hits;
    // Each enabled condition on its own drives the request.
    nxt_srq = |enabled_hits;
    // Every enabled lane raises the request on its own, whatever the
    // others do, so several enables may stand together.
    // The request falls as soon as no enabled condition remains.
    if (!(|enabled_hits)) begin
      nxt_srq = 1'b0;
    end
  end

  // All state freezes while the clock enable is low, so a held enable
  // never loses a pending write or a committed mask.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_ff     <= `SRM_MASK_RESET;
      pend_ff     <= `SRM_MASK_RESET;
      pend_vld_ff <= 1'b0;
      stb_ff      <= `SRM_ZERO_BYTE;
    end else if (ce) begin
      mask_ff     <= nxt_mask;
      pend_ff     <= nxt_pend;
      pend_vld_ff <= nxt_pend_vld;
      stb_ff      <= nxt_stb;
    end
  end

  // Query answer. The data holds until the next query, so a slow reader
  // can still take it after the one-cycle valid has gone.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_ff  <= `SRM_ZERO_BYTE;
      rd_valid_ff <= 1'b0;
    end else if (ce) begin
      rd_valid_ff <= mask_rd;
      // Query reports the mask in force, not a pending write.
      if (mask_rd) begin
        rd_data_ff <= mask_ff;
      end
    end
  end

  // The line is open drain: it is pulled low while a request stands and
  // released otherwise. Both pin bits sit in flops so that no glitch of
  // the request logic can reach the bus.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      srq_out_ff  <= `SRM_SRQ_DATA;
      srq_oe_n_ff <= `SRM_SRQ_RELEASED;
    end else if (ce) begin
      srq_out_ff  <= `SRM_SRQ_DATA;
      srq_oe_n_ff <= ~nxt_srq;
    end
  end

  // Serial-poll view of the byte and the mask.
  assign mask_rd_data        = rd_data_ff;
  assign mask_rd_valid       = rd_valid_ff;
  assign status_summary_byte = stb_ff;
  assign request_enable_mask = mask_ff;

  // Enable is active low: low while the module pulls the line.
  // The data bit stays low, so a released line floats to its pull-up.
  assign srq_out  = srq_out_ff;
  assign srq_oe_n = srq_oe_n_ff;

endmodule // srm_top

// [tb/srm_assertions.sv]
// Concurrent checks on the ports of the service request mask logic.
`timescale 1ns/10ps
module srm_assertions (
  // Clock, reset and enable.
  input wire       clk,
  input wire       rst,
  input wire       ce,
  // Commands.
  input wire       mask_wr,
  input wire       exec_cmd,
  input wire       mask_rd,
  input wire       por_cmd,
  input wire       dev_clear,
  input wire [7:0] mask_wr_data,
  // Conditions.
  input wire       cond_overrun,
  input wire       cond_event,
  input wire       cond_msg,
  input wire       cond_scan,
  input wire       cond_ready,
  input wire       cond_trig,
  input wire       cond_alarm,
  // Outputs.
  input wire [7:0] mask_rd_data,
  input wire [7:0] status_summary_byte,
  input wire [7:0] request_enable_mask,
  input wire       mask_rd_valid,
  input wire       srq_out,
  input wire       srq_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_query; ce && mask_rd; endsequence
  sequence s_answer;
    mask_rd_valid && mask_rd_data == $past(request_enable_mask);
  endsequence
  property p_rd; s_query |=> s_answer; endproperty
  property p_idle; ce && !mask_rd |=> !mask_rd_valid; endproperty
  property p_clear;
    ce && (por_cmd || dev_clear) |=> request_enable_mask == 8'h00;
  endproperty
  property p_hold;
    !(ce && (exec_cmd || por_cmd || dev_clear)) |=>
      $stable(request_enable_mask);
  endproperty
  property p_bit6;
    ce && $past(ce) |-> status_summary_byte[6] ==
      |(status_summary_byte & $past(request_enable_mask) & 8'hBF);
  endproperty
  // The request follows the enabled lanes of the byte it is shown with.
  property p_srq;
    ce && $past(ce) |-> srq_oe_n ==
      !(|(status_summary_byte & $past(request_enable_mask) & 8'hBF));
  endproperty
  property p_od; srq_out == 1'h0; endproperty
  property p_no6; request_enable_mask[6] == 1'h0; endproperty
  a_rd: assert property (p_rd)
    else $error("bad query answer");
  a_idle: assert property (p_idle)
    else $error("stray valid");
  a_clear: assert property (p_clear)
    else $error("mask not cleared");
  a_hold: assert property (p_hold)
    else $error("mask changed");
  a_bit6: assert property (p_bit6)
    else $error("bad summary");
  a_srq: assert property (p_srq)
    else $error("bad request");
  a_od: assert property (p_od)
    else $error("line driven high");
  a_no6: assert property (p_no6)
    else $error("bit 6 enabled");
endmodule // srm_assertions
bind srm_top srm_assertions i_srm_assertions (.clk(clk), .rst(rst),
  .ce(ce), .mask_wr(mask_wr), .exec_cmd(exec_cmd), .mask_rd(mask_rd),
  .por_cmd(por_cmd), .dev_clear(dev_clear), .mask_wr_data(mask_wr_data),
  .cond_overrun(cond_overrun), .cond_event(cond_event),
  .cond_msg(cond_msg), .cond_scan(cond_scan), .cond_ready(cond_ready),
  .cond_trig(cond_trig), .cond_alarm(cond_alarm),
  .mask_rd_data(mask_rd_data), .status_summary_byte(status_summary_byte),
  .request_enable_mask(request_enable_mask),
  .mask_rd_valid(mask_rd_valid), .srq_out(srq_out), .srq_oe_n(srq_oe_n));

// [tb/srm_ctrl_model.sv]
// Bus controller side of the service request line.
`timescale 1ns/10ps
module srm_ctrl_model (
  input  wire srq_out,
  input  wire srq_oe_n,
  output wire srq_line
);
  // The bus has a pull-up, so a released line reads high.
  assign srq_line = srq_oe_n ? 1'h1 : srq_out;
endmodule // srm_ctrl_model

// [tb/srm_tb_top.sv]
// Testbench for the service request mask logic.
`timescale 1ns/10ps
module srm_tb_top;
  logic       clk = 0, rst = 1, ce = 1, wr = 0, ex = 0, rd = 0;
  logic       por = 0, dcl = 0;
  logic [7:0] wd = 8'h00, cond = 8'h00;
  wire  [7:0] rdd, stb, msk;
  wire        rdv, so, soe, srq_line;
  int         n_errors = 0, n_compared = 0;
  initial forever #5 clk = ~clk;
  srm_top i_srm_top (.clk(clk), .rst(rst), .ce(ce), .mask_wr(wr),
    .mask_wr_data(wd), .exec_cmd(ex), .mask_rd(rd), .mask_rd_data(rdd),
    .mask_rd_valid(rdv), .por_cmd(por), .dev_clear(dcl),
    .cond_overrun(cond[7]), .cond_event(cond[5]), .cond_msg(cond[4]),
    .cond_scan(cond[3]), .cond_ready(cond[2]), .cond_trig(cond[1]),
    .cond_alarm(cond[0]), .status_summary_byte(stb),
    .request_enable_mask(msk), .srq_out(so), .srq_oe_n(soe));
  srm_ctrl_model i_srm_ctrl_model (.srq_out(so), .srq_oe_n(soe),
    .srq_line(srq_line));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One-cycle command pulses, launched and dropped on falling edges.
  task automatic pulse(input logic w1, x, r, p, d, input logic [7:0] v);
    @(negedge clk);
    {wr, ex, rd, por, dcl, wd} = {w1, x, r, p, d, v};
    @(negedge clk);
    {wr, ex, rd, por, dcl} = 5'h00;
  endtask
  task automatic query(input logic [7:0] exp);
    pulse(0, 0, 1, 0, 0, 8'h00);
    chk({7'h00, rdv}, 8'h01);
    chk(rdd, exp);
  endtask
  task automatic wait_sync;
    repeat (4) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_reset;
    chk(msk, 8'h00);
    chk({7'h00, soe}, 8'h01);
    query(8'h00);
  endtask
  // Each enable alone: other conditions stay masked, its own one fires.
  task automatic t_bits;
    for (int i = 7; i >= 0; i--) begin
      if (i != 6) begin
        pulse(1, 1, 0, 0, 0, 8'h00);
        pulse(1, 1, 0, 0, 0, 8'h01 << i);
        chk(msk, 8'h01 << i);
        cond = ~(8'h01 << i) & 8'hBF;
        wait_sync;
        chk({7'h00, srq_line}, 8'h01);
        cond = 8'h01 << i;
        wait_sync;
        chk(stb, cond | 8'h40);
        chk({7'h00, srq_line}, 8'h00);
        cond = 8'h00;
        wait_sync;
        chk({7'h00, soe}, 8'h01);
      end
    end
  endtask
  // Separate writes before one execute combine; bit 6 never sticks.
  task automatic t_or;
    pulse(1, 1, 0, 0, 0, 8'h00);
    pulse(1, 0, 0, 0, 0, 8'h01);
    pulse(1, 0, 0, 0, 0, 8'h02);
    pulse(0, 1, 0, 0, 0, 8'h00);
    chk(msk, 8'h03);
    pulse(1, 1, 0, 0, 0, 8'h00);
    pulse(1, 1, 0, 0, 0, 8'hFF);
    query(8'hBF);
  endtask
  // Power-on command, device clear and zero write each empty the mask.
  task automatic t_clear;
    for (int k = 0; k < 3; k++) begin
      pulse(1, 1, 0, 0, 0, 8'h81);
      chk(msk, 8'h81);
      pulse(k == 2, k == 2, 0, k == 0, k == 1, 8'h00);
      chk(msk, 8'h00);
    end
  endtask
  // Enable low freezes everything; a lone execute later commits nothing.
  task automatic t_freeze;
    pulse(1, 1, 0, 0, 0, 8'h04);
    ce = 0;
    pulse(1, 1, 0, 0, 0, 8'h10);
    pulse(0, 0, 0, 1, 0, 8'h00);
    chk(msk, 8'h04);
    ce = 1;
    pulse(0, 1, 0, 0, 0, 8'h00);
    chk(msk, 8'h04);
    query(8'h04);
  endtask
  initial begin
    #100us;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_reset();
    t_bits();
    t_or();
    t_clear();
    t_freeze();
    wrap_up();
  end
endmodule // srm_tb_top
